// ==== pls_pkg.sv ====
package pls_pkg;

  localparam int WORD_W = 32;
  localparam int LANES = 4;
  localparam int CHUNK_W = 16;

  // payload bits per lane and frame length (two start bits, invert flag, data)
  localparam logic [4:0] CHUNK_DUAL = 5'h10;
  localparam logic [4:0] CHUNK_QUAD = 5'h08;
  localparam logic [4:0] FRAME_DUAL = 5'h13;
  localparam logic [4:0] FRAME_QUAD = 5'h0B;

  // running disparity never leaves this window
  localparam logic signed [7:0] DISP_LIMIT = 8'sh14;

  // additive scrambler, one step per word
  localparam logic [31:0] SCR_SEED = 32'hFFFF_FFFF;
  localparam logic [31:0] SCR_POLY = 32'h8020_0003;

  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_WORDS = 12'h008;

  // control fields
  localparam int CTRL_SCR_EN = 0;
  localparam int CTRL_SOFT_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // status fields
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_QUAD = 1;
  localparam int STAT_BIST = 2;
  localparam int STAT_OVERRUN = 3;

  // pin group, synchronised as one
  typedef struct packed {
    logic clk_in;
    logic power_down_n;
    logic strobe_edge_select;
    logic self_test_enable;
    logic quad_lane_select;
  } pls_pins_t;

endpackage

// ==== pls_lane.sv ====
`timescale 1ns/1ns
`default_nettype none

module pls_lane (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic load,
  input wire logic quad,
  input wire logic [15:0] chunk,
  output logic lane_bit,
  output logic busy
);

  logic [18:0] shift_reg, shift_next;
  logic [4:0] left_reg, left_next;
  logic signed [7:0] rd_reg, rd_next;
  logic [4:0] ones;
  logic signed [7:0] disp;
  logic inv;
  logic [15:0] masked;

  always_comb begin
    masked = quad ? {8'h00, chunk[7:0]} : chunk;
    ones = 5'h00;
    for (int i = 0; i < 16; i++) begin
      ones = ones + {4'h0, masked[i]};
    end
    disp = $signed({2'b00, ones, 1'b0}) -
           $signed({3'b000, (quad ? pls_pkg::CHUNK_QUAD : pls_pkg::CHUNK_DUAL)});
    // RL7 dc balance inversion
    // invert when the chunk would push disparity further the same way;
    // a balanced chunk below zero inverts too, so its flag bit pulls back up
    inv = ((rd_reg > 0) && (disp > 0)) || ((rd_reg < 0) && (disp <= 0));
    shift_next = shift_reg;
    left_next = left_reg;
    rd_next = rd_reg;
    if (clear) begin
      shift_next = 19'h00000;
      left_next = 5'h00;
      rd_next = 8'sh00;
    end else if (load) begin
      // RL8 embedded clock edge
      // every frame opens with a 1-to-0 transition
      shift_next = {(inv ? ~masked : masked), inv, 1'b0, 1'b1};
      if (quad) begin
        shift_next[18:11] = 8'h00;
      end
      left_next = quad ? pls_pkg::FRAME_QUAD : pls_pkg::FRAME_DUAL;
      rd_next = inv ? (rd_reg - disp + 8'sh01) : (rd_reg + disp - 8'sh01);
    end else if (left_reg != 5'h00) begin
      shift_next = {1'b0, shift_reg[18:1]};
      left_next = left_reg - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 19'h00000;
      left_reg <= 5'h00;
      rd_reg <= 8'sh00;
    end else begin
      shift_reg <= shift_next;
      left_reg <= left_next;
      rd_reg <= rd_next;
    end
  end

  assign busy = (left_reg != 5'h00);
  assign lane_bit = busy & shift_reg[0];

  // RL7 dc balance bound
  a_disp_bound: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (rd_reg <= pls_pkg::DISP_LIMIT) && (rd_reg >= -pls_pkg::DISP_LIMIT))
    else $error("running disparity out of range");

  // RL8 frame start marker
  a_frame_marker: assert property (@(posedge pclk) disable iff (!presetn || clear) // RL8
    load |=> lane_bit ##1 !lane_bit)
    else $error("frame did not open with clock transition");

endmodule

`default_nettype wire

// ==== pls_serializer.sv ====
`timescale 1ns/1ns
`default_nettype none

//Behaviour
// RL1 - one 32-bit word per parallel clock, serialized onto two or four lanes
// RL2 - lane select low gives two lanes, high gives four lanes
// RL3 - driver keeps parallel clock 20-50 MHz dual, 40-85 MHz quad
// RL4 - strobe select high samples on rising edge, low on falling edge
// RL5 - power-down low disables device, serial outputs float, serializer stopped
// RL6 - self-test low sends data, high sends built-in test pattern
// RL7 - payload scrambled, each lane stream dc balanced before sending
// RL8 - timing embedded in serial frames, no separate clock line needed
// RL9 - receiver locks to data alone, no reference clock or sync pattern
// RL10 - receiver removes lane-to-lane skew before rebuilding the word
// RL11 - fixed bit-to-lane-and-slot mapping per lane count on both ends
// RL12 - driver changes lane select only in power-down, keeps clock steady
module pls_serializer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parallel_clock_in,
  input wire logic [31:0] parallel_word_in,
  input wire logic power_down_n,
  input wire logic strobe_edge_select,
  input wire logic self_test_enable,
  input wire logic quad_lane_select,
  output logic [3:0] serial_lane_out,
  output logic [3:0] serial_lane_oe
);

  pls_pkg::pls_pins_t pins_now, pins_s1_reg, pins_s2_reg;
  logic [31:0] word_s1_reg, word_s2_reg;
  logic clk_prev_reg, clk_prev_next;
  logic active_reg, active_next;
  logic quad_reg, quad_next;
  logic [31:0] lfsr_reg, lfsr_next;
  logic [31:0] words_reg, words_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic overrun_reg, overrun_next;
  logic [3:0] out_reg, out_next;
  logic [3:0] oe_reg, oe_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic strobe, rise, fall, any_busy, load, clear;
  logic [31:0] payload, scrambled;
  logic [15:0] chunk [4];
  logic [3:0] lane_bit, lane_busy, lane_used;
  logic apb_access, apb_wr;

  assign pins_now = '{clk_in: parallel_clock_in, power_down_n: power_down_n,
                      strobe_edge_select: strobe_edge_select,
                      self_test_enable: self_test_enable,
                      quad_lane_select: quad_lane_select};

  // two-stage synchronisers; only stage two is ever read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      word_s1_reg <= 32'h0000_0000;
      word_s2_reg <= 32'h0000_0000;
    end else begin
      pins_s1_reg <= pins_now;
      pins_s2_reg <= pins_s1_reg;
      word_s1_reg <= parallel_word_in;
      word_s2_reg <= word_s1_reg;
    end
  end

  // clock and data share the same sync depth, so they stay aligned
  assign rise = pins_s2_reg.clk_in & ~clk_prev_reg;
  assign fall = ~pins_s2_reg.clk_in & clk_prev_reg;

  // RL4 strobe edge choice
  assign strobe = pins_s2_reg.strobe_edge_select ? rise : fall;

  assign any_busy = |lane_busy;
  assign load = active_reg & strobe & ~any_busy;
  assign clear = ~active_reg;

  // RL6 test pattern replaces payload
  assign payload = pins_s2_reg.self_test_enable ? {words_reg[15:0], ~words_reg[15:0]}
                                                : word_s2_reg;

  // RL7 additive scrambling
  assign scrambled = ctrl_reg[pls_pkg::CTRL_SCR_EN] ? (payload ^ lfsr_reg) : payload;

  // RL11 dual: 16 bits per lane, quad: 8 bits per lane, lsb first
  always_comb begin
    if (quad_reg) begin
      for (int l = 0; l < 4; l++) begin
        chunk[l] = {8'h00, scrambled[l*8 +: 8]};
      end
    end else begin
      chunk[0] = scrambled[15:0];
      chunk[1] = scrambled[31:16];
      chunk[2] = 16'h0000;
      chunk[3] = 16'h0000;
    end
  end

  // RL2 lanes in use
  assign lane_used = quad_reg ? 4'hF : 4'h3;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      pls_lane u_lane (
        .pclk(pclk),
        .presetn(presetn),
        .clear(clear),
        .load(load & lane_used[g]),
        .quad(quad_reg),
        .chunk(chunk[g]),
        .lane_bit(lane_bit[g]),
        .busy(lane_busy[g])
      );
    end
  endgenerate

  assign apb_access = psel & penable & ~pready_reg;
  // write lands on the completing edge, where pready is seen high
  assign apb_wr = psel & penable & pready_reg & pwrite;

  always_comb begin
    clk_prev_next = pins_s2_reg.clk_in;
    // RL5 power-down and soft enable gate the whole datapath
    active_next = pins_s2_reg.power_down_n & ctrl_reg[pls_pkg::CTRL_SOFT_EN];
    // lane count only follows the pin while idle, never mid-stream
    quad_next = active_reg ? quad_reg : pins_s2_reg.quad_lane_select;
    lfsr_next = lfsr_reg;
    words_next = words_reg;
    overrun_next = overrun_reg;
    ctrl_next = ctrl_reg;
    if (!active_reg) begin
      lfsr_next = pls_pkg::SCR_SEED;
    end else if (load) begin
      // RL1 one word taken per strobe while no lane is busy
      lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ pls_pkg::SCR_POLY) : (lfsr_reg >> 1);
      words_next = words_reg + 32'h0000_0001;
    end
    // RL5 outputs float in standby
    out_next = lane_bit & lane_used & {4{active_reg}};
    oe_next = lane_used & {4{active_reg}};
    prdata_next = prdata_reg;
    pready_next = apb_access;
    pslverr_next = 1'b0;
    if (apb_wr && paddr == pls_pkg::ADDR_CTRL) begin
      ctrl_next = pwdata[1:0];
    end
    // overrun is write-one-to-clear; a new overrun wins over the clear
    if (apb_wr && paddr == pls_pkg::ADDR_STATUS && pwdata[pls_pkg::STAT_OVERRUN]) begin
      overrun_next = 1'b0;
    end
    if (active_reg && strobe && any_busy) begin
      overrun_next = 1'b1;
    end
    if (apb_access) begin
      case (paddr)
        pls_pkg::ADDR_CTRL: prdata_next = {30'h0000_0000, ctrl_reg};
        pls_pkg::ADDR_STATUS: prdata_next = {28'h000_0000, overrun_reg,
                                             pins_s2_reg.self_test_enable, quad_reg,
                                             active_reg};
        pls_pkg::ADDR_WORDS: prdata_next = words_reg;
        default: begin
          prdata_next = 32'h0000_0000;
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_reg <= 1'b0;
      active_reg <= 1'b0;
      quad_reg <= 1'b0;
      lfsr_reg <= pls_pkg::SCR_SEED;
      words_reg <= 32'h0000_0000;
      ctrl_reg <= pls_pkg::CTRL_RESET;
      overrun_reg <= 1'b0;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_prev_next;
      active_reg <= active_next;
      quad_reg <= quad_next;
      lfsr_reg <= lfsr_next;
      words_reg <= words_next;
      ctrl_reg <= ctrl_next;
      overrun_reg <= overrun_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign serial_lane_out = out_reg;
  assign serial_lane_oe = oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // RL2 dual mode lanes
  a_dual_lanes: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !quad_reg |-> serial_lane_oe[3:2] == 2'b00)
    else $error("upper lanes driven in dual mode");

  // RL2 quad lanes on
  a_quad_lanes: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    (quad_reg && $past(quad_reg) && active_reg && $past(active_reg)) |-> serial_lane_oe == 4'hF)
    else $error("quad mode not driving four lanes");

  // RL5 standby floats outputs
  a_standby_float: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    !pins_s2_reg.power_down_n |-> ##2 (serial_lane_oe == 4'h0 && serial_lane_out == 4'h0))
    else $error("outputs driven during power-down");

  // RL1 word counted on load
  a_word_count: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    load |=> words_reg == $past(words_reg) + 32'h0000_0001)
    else $error("accepted word not counted");

  // RL4 load only on chosen edge
  a_strobe_edge: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    load |-> (pins_s2_reg.strobe_edge_select ?
              (pins_s2_reg.clk_in && !clk_prev_reg) : (!pins_s2_reg.clk_in && clk_prev_reg)))
    else $error("word taken on wrong clock edge");

  // RL6 self-test pattern
  a_bist_pattern: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    pins_s2_reg.self_test_enable |-> payload[31:16] == ~payload[15:0])
    else $error("self-test payload wrong");

  // RL7 scrambler advances per word
  a_scramble_step: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (load && active_next) |=> lfsr_reg != $past(lfsr_reg))
    else $error("scrambler did not advance");

  // RL11 quad lane mapping
  a_lane_map: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (load && quad_reg) |-> (chunk[1][7:0] == scrambled[15:8] && chunk[3][7:0] == scrambled[31:24]))
    else $error("lane mapping broken");

  // RL8 serial frame leads with clock edge
  a_out_frame: assert property (@(posedge pclk) // RL8
    disable iff (!presetn || !active_reg)
    load |-> ##2 serial_lane_out[0] ##1 !serial_lane_out[0])
    else $error("serial frame missing clock transition");

  // RL1 refused word flagged
  a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (active_reg && strobe && any_busy) |=> (overrun_reg && words_reg == $past(words_reg)))
    else $error("dropped word not flagged");

  // RL1 count only on load
  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    !load |=> words_reg == $past(words_reg))
    else $error("word count moved without a load");

  // RL2 lane count frozen
  a_quad_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    (active_reg && $past(active_reg)) |-> quad_reg == $past(quad_reg))
    else $error("lane count changed while active");

  // RL2 upper lanes quiet
  a_upper_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !quad_reg |=> serial_lane_out[3:2] == 2'b00)
    else $error("upper lane data in dual mode");

  // RL4 one load per edge
  a_single_load: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    load |=> !load)
    else $error("one clock edge loaded twice");

  // RL5 no data while idle
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    !active_reg |=> serial_lane_out == 4'h0)
    else $error("lane data while inactive");

  // RL6 test word unscrambled
  a_bist_plain: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    (load && pins_s2_reg.self_test_enable && !ctrl_reg[pls_pkg::CTRL_SCR_EN]) |->
    scrambled[31:16] == ~scrambled[15:0])
    else $error("self-test word altered");

  // RL7 scrambler reseeded idle
  a_reseed_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    !active_reg |=> lfsr_reg == pls_pkg::SCR_SEED)
    else $error("scrambler not reseeded");

endmodule

`default_nettype wire

// ==== pls_rx_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module pls_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic quad,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe,
  output logic [31:0] word,
  output logic valid
);
  int st[4];
  logic [3:0] inv;
  logic [3:0] got;
  logic [15:0] sh[4];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got = 4'h0;
      valid <= 1'b0;
      st = '{default: 0};
    end else begin
      for (int l = 0; l < 4; l++) begin
        // frames found from start bits alone
        if (!lane_oe[l] || (!quad && l > 1)) begin
          st[l] = 0;
          got[l] = 1'b0;
        end else if (st[l] == 0) begin
          st[l] = lane_out[l] ? 1 : 0;
        end else if (st[l] == 1) begin
          st[l] = lane_out[l] ? 0 : 2;
        end else if (st[l] == 2) begin
          inv[l] = lane_out[l];
          st[l] = 3;
        end else begin
          // lsb arrives first, so it ends up lowest after the shifts
          sh[l] = {lane_out[l] ^ inv[l], sh[l][15:1]};
          st[l]++;
          if (st[l] == (quad ? 11 : 19)) begin
            got[l] = 1'b1;
            st[l] = 0;
          end
        end
      end
      // lanes wait for each other, fixed bit places
      if (quad && got == 4'hF) begin
        word <= {sh[3][15:8], sh[2][15:8], sh[1][15:8], sh[0][15:8]};
        valid <= 1'b1;
        got = 4'h0;
      end else if (!quad && got[1:0] == 2'h3) begin
        word <= {sh[1], sh[0]};
        valid <= 1'b1;
        got = 4'h0;
      end else begin
        valid <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic pclk, pready, pslverr, err, rx_valid;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic clk_in = 1'b0, pdn_n = 1'b0, rise = 1'b1, bist = 1'b0, quad = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, win = 32'h0;
  logic [31:0] prdata, rq, rx_word, lfsr;
  logic [3:0] lane, lane_oe;
  logic [31:0] exp_q[$];
  int num_errors = 0, checks_done = 0, seed = 32'h7672, rx_count = 0, sent = 0;
  bit scr = 1, cmp_on = 1;

  pls_serializer pls_serializer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parallel_clock_in(clk_in),
    .parallel_word_in(win), .power_down_n(pdn_n), .strobe_edge_select(rise),
    .self_test_enable(bist), .quad_lane_select(quad), .serial_lane_out(lane),
    .serial_lane_oe(lane_oe));
  pls_rx_model pls_rx_model_i (.pclk(pclk), .presetn(presetn), .quad(quad),
    .lane_out(lane), .lane_oe(lane_oe), .word(rx_word), .valid(rx_valid));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // idle level of the link clock is the unselected one, so it stands still
  task automatic activate(input logic q, input logic r);
    pdn_n <= 1'b0;
    tick(5);
    quad <= q;
    rise <= r;
    clk_in <= ~r;
    tick(5);
    pdn_n <= 1'b1;
    tick(8);
    lfsr = 32'hFFFF_FFFF;
  endtask

  // one 125 ns link clock cycle per word, still between words
  // data changes at or after the unselected edge, well clear of the selected one
  task automatic send(input int gap);
    logic [31:0] w;
    w = $random(seed);
    win <= w;
    if (bist) w = {sent[15:0], ~sent[15:0]};
    sent++;
    if (cmp_on) exp_q.push_back(scr ? w ^ lfsr : w);
    lfsr = lfsr[0] ? (lfsr >> 1) ^ pls_pkg::SCR_POLY : lfsr >> 1;
    #63;
    clk_in <= rise;
    #62;
    clk_in <= ~rise;
    tick(gap);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      tick(1);
      n++;
    end
    chk("words left", 32'h0, exp_q.size());
    tick(30);
  endtask

  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      rx_count++;
      if (cmp_on) chk("rx word", exp_q.size() ? exp_q.pop_front() : ~rx_word, rx_word);
    end
  end

  initial begin
    #400000;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    tick(5);
    presetn <= 1'b1;
    apb(1'b0, pls_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", {30'h0, pls_pkg::CTRL_RESET}, rq);
    apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
    chk("status reset", 32'h0, rq);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped read", 32'h0, rq);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int m = 0; m < 4; m++) begin
      activate(m[0], m[1]);
      apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
      chk("status mode", {30'h0, m[0], 1'b1}, rq);
      repeat (5) send(m[0] ? 0 : 10);
      drain();
    end
    apb(1'b1, pls_pkg::ADDR_CTRL, 32'h2);
    scr = 0;
    bist <= 1'b1;
    activate(1'b1, 1'b1);
    apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
    chk("status test", 32'h7, rq);
    repeat (4) send(0);
    drain();
    bist <= 1'b0;
    apb(1'b1, pls_pkg::ADDR_CTRL, 32'h3);
    scr = 1;
    // dual lanes at full link rate cannot keep up
    cmp_on = 0;
    activate(1'b0, 1'b1);
    repeat (4) send(0);
    tick(40);
    apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
    chk("status overrun", 32'h9, rq);
    apb(1'b1, pls_pkg::ADDR_STATUS, 32'h8);
    apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
    chk("status cleared", 32'h1, rq);
    apb(1'b1, pls_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, pls_pkg::ADDR_STATUS, 32'h0);
    chk("status soft off", 32'h0, rq);
    apb(1'b1, pls_pkg::ADDR_CTRL, 32'h3);
    cmp_on = 1;
    pdn_n <= 1'b0;
    // two sync stages, the active flop, then the output flop
    tick(5);
    chk("lane enable", 32'h0, {28'h0, lane_oe});
    chk("lane out", 32'h0, {28'h0, lane});
    apb(1'b1, pls_pkg::ADDR_WORDS, 32'h0);
    apb(1'b0, pls_pkg::ADDR_WORDS, 32'h0);
    chk("word count", rx_count, rq);
    tally_and_finish;
  end
endmodule

`default_nettype wire
